// ===== dv/scd_clock_delay_trim_assertions.sv
/* Checker for the trim and coarse delay outputs of the register block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module scd_clock_delay_trim_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] sample_clock_divide_ratio,
	input wire logic [2:0] amplitude_trim_a,
	input wire logic [3:0] phase_trim_a,
	input wire logic [2:0] amplitude_trim_b,
	input wire logic [3:0] phase_trim_b,
	input wire scd_pkg::scd_trim_type trim_a,
	input wire scd_pkg::scd_trim_type trim_b,
	input wire logic coarse_delay_enable,
	input wire logic [3:0] coarse_delay_code,
	input wire scd_pkg::scd_delay_type delay_a,
	input wire scd_pkg::scd_delay_type delay_b,
	input wire logic burst_restart
);
	// ------------------------------------------------------------------
	// Expected decodes
	// ------------------------------------------------------------------
	// Phase steps cap at seven: the top code means 1.68 pF, not wrap
	function automatic logic [6:0] trim_of(input logic [2:0] a, input logic [3:0] p);
		trim_of = {a != 3'h0 && !a[2], a[1:0], p[3],
			p[3] ? ((&p[2:0]) ? 3'h7 : p[2:0] + 3'h1) : p[2:0]};
	endfunction
	// Codes below the limit add two half periods; the next ones wrap to 0, then 1
	function automatic logic [4:0] dly_of(input logic en, input logic [1:0] r, input logic [3:0] c);
		logic ok;
		logic [3:0] lim;
		ok = (r == 2'h3) ? c != 4'hF : (r == 2'h2) ? c < 4'h8 : (r == 2'h1) ? c < 4'h4 : 1'b0;
		lim = (r == 2'h3) ? 4'hE : (r == 2'h2) ? 4'h6 : 4'h2;
		dly_of = (en && ok) ? {1'b1, (c < lim) ? c + 4'h2 : c - lim} : 5'h00;
	endfunction
	wire [6:0] exp_a = trim_of(amplitude_trim_a, phase_trim_a);
	wire [6:0] exp_b = trim_of(amplitude_trim_b, phase_trim_b);
	wire [4:0] exp_d = dly_of(coarse_delay_enable, sample_clock_divide_ratio, coarse_delay_code);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	sequence s_ctrl_changed;
		$changed({coarse_delay_enable, coarse_delay_code});
	endsequence
	sequence s_div8_first;
		sample_clock_divide_ratio == 2'h3 && coarse_delay_enable && coarse_delay_code == 4'h0;
	endsequence
	property p_trim_a; 1'b1 |=> trim_a == $past(exp_a); endproperty
	property p_trim_b; 1'b1 |=> trim_b == $past(exp_b); endproperty
	property p_delay; 1'b1 |=> delay_a == $past(exp_d); endproperty
	property p_same; delay_a == delay_b; endproperty
	property p_restart_cause; s_ctrl_changed |-> burst_restart; endproperty
	property p_restart_pulse; burst_restart |=> !burst_restart; endproperty
	property p_div1; sample_clock_divide_ratio == 2'h0 |=> delay_a == 5'h00; endproperty
	property p_off; !coarse_delay_enable |=> !delay_a.applied && delay_a.half_periods == 4'h0; endproperty
	property p_div8; s_div8_first |=> delay_a.applied && delay_a.half_periods == 4'h2; endproperty
	a_trim_a: assert property (p_trim_a) else $error("trim a decode wrong");
	a_trim_b: assert property (p_trim_b) else $error("trim b decode wrong");
	a_delay: assert property (p_delay) else $error("delay decode wrong");
	a_same: assert property (p_same) else $error("channel delays differ");
	a_restart_cause: assert property (p_restart_cause) else $error("no restart");
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
	a_div1: assert property (p_div1) else $error("delay at divide by one");
	a_off: assert property (p_off) else $error("delay while disabled");
	a_div8: assert property (p_div8) else $error("divide by eight code 0 wrong");
endmodule
bind scd_clock_delay_trim scd_clock_delay_trim_assertions u_chk (.mclk(mclk), .rst(rst),
	.sample_clock_divide_ratio(sample_clock_divide_ratio), .amplitude_trim_a(amplitude_trim_a),
	.phase_trim_a(phase_trim_a), .amplitude_trim_b(amplitude_trim_b), .phase_trim_b(phase_trim_b),
	.trim_a(trim_a), .trim_b(trim_b), .coarse_delay_enable(coarse_delay_enable),
	.coarse_delay_code(coarse_delay_code), .delay_a(delay_a), .delay_b(delay_b),
	.burst_restart(burst_restart));

// ===== dv/scd_host_model.sv
/* Host controller model: drives serial frames into the register block.
   Assumes the bench calls xfer and mclk is the device clock. */
`timescale 1ns/1ps
module scd_host_model (
	input wire logic mclk,
	input wire logic spi_sdo,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi
);
	// Idle: deselected, serial clock parked low
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end
	// One frame, MSB first; fewer than 24 bits aborts it
	// Caller zeroes reserved bits and never writes during calibration
	task automatic xfer(input logic [23:0] frame, input int nbits, output logic [7:0] q);
		q = 8'h00;
		@(negedge mclk) spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_sdi = frame[23 - i];
			spi_sclk = 1'b0;
			repeat (2) @(negedge mclk);
			q = {q[6:0], spi_sdo};
			spi_sclk = 1'b1;
			repeat (2) @(negedge mclk);
		end
		spi_sclk = 1'b0;
		// Released line must not keep a stale bit
		spi_sdi = ~spi_sdi;
		@(negedge mclk) spi_cs_n = 1'b1;
		repeat (2) @(negedge mclk);
	endtask
endmodule

// ===== dv/tb.sv
/* Self-checking bench for the trim and coarse delay register block.
   Assumes the host model and the checker files are compiled alongside. */
`timescale 1ns/1ps
`include "scd_defines.svh"
module tb;
	logic mclk, rst, tog, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_en, sdo_line;
	logic [1:0] ratio;
	logic [2:0] amp_a, amp_b;
	logic [3:0] ph_a, ph_b, dly_code;
	logic dly_en, burst_restart;
	scd_pkg::scd_trim_type trim_a, trim_b;
	scd_pkg::scd_delay_type delay_a, delay_b;
	int n_fail, comparisons, n_burst;
	logic [7:0] q;
	// Clock and a toggling level for the undriven read line
	initial mclk = 1'b0;
	initial tog = 1'b0;
	always #10 mclk = ~mclk;
	always @(posedge mclk) tog <= ~tog;
	always @(posedge mclk) if (burst_restart === 1'b1) n_burst++;
	assign sdo_line = spi_sdo_en ? spi_sdo : tog;
	scd_host_model host (.mclk(mclk), .spi_sdo(sdo_line), .spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk), .spi_sdi(spi_sdi));
	scd_clock_delay_trim DUT (.mclk(mclk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_en(spi_sdo_en),
		.sample_clock_divide_ratio(ratio), .amplitude_trim_a(amp_a), .phase_trim_a(ph_a),
		.amplitude_trim_b(amp_b), .phase_trim_b(ph_b), .trim_a(trim_a), .trim_b(trim_b),
		.coarse_delay_enable(dly_en), .coarse_delay_code(dly_code), .delay_a(delay_a),
		.delay_b(delay_b), .burst_restart(burst_restart));
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d}, 24, q);
	endtask
	task automatic rd(input logic [14:0] a);
		host.xfer({1'b1, a, 8'h00}, 24, q);
	endtask
	task automatic summarize;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Everything zero out of reset
	task automatic t_reset;
		check({1'b0, trim_a}, 8'h00, "trim a reset");
		check({1'b0, trim_b}, 8'h00, "trim b reset");
		check({3'h0, delay_a}, 8'h00, "delay reset");
		rd(`SCD_ADDR_TRIM_A);
		check(q, `SCD_RST_TRIM_A, "read a");
		rd(`SCD_ADDR_TRIM_B);
		check(q, `SCD_RST_TRIM_B, "read b");
		rd(`SCD_ADDR_DELAY_CTRL);
		check(q, `SCD_RST_DELAY_CTRL, "read ctrl");
	endtask
	// Trim codes on both sides, reserved amplitude code, top phase code
	task automatic t_trim;
		logic [22:0] tab [4] = '{{1'b0, 8'h37, 7'h77, 7'h00}, {1'b1, 8'h58, 7'h19, 7'h00},
			{1'b0, 8'h4F, 7'h0F, 7'h00}, {1'b1, 8'h29, 7'h6A, 7'h00}};
		int nb;
		logic [6:0] raw, dec;
		nb = n_burst;
		foreach (tab[i]) begin
			wr(tab[i][22] ? `SCD_ADDR_TRIM_B : `SCD_ADDR_TRIM_A, tab[i][21:14]);
			raw = tab[i][22] ? {amp_b, ph_b} : {amp_a, ph_a};
			dec = tab[i][22] ? trim_b : trim_a;
			check({1'b0, raw}, {1'b0, tab[i][20:14]}, "raw trim");
			check({1'b0, dec}, {1'b0, tab[i][13:7]}, "trim decode");
			rd(tab[i][22] ? `SCD_ADDR_TRIM_B : `SCD_ADDR_TRIM_A);
			check(q, tab[i][21:14], "trim readback");
		end
		check(8'(n_burst - nb), 8'h00, "restart on trim write");
	endtask
	// Delay tables for every divide ratio, reserved codes, disabled
	// Delay is switched off before the ratio drops to one: the host may not use it there
	task automatic t_delay;
		logic [17:0] tab [13] = '{{2'h3, 8'h10, 8'h12}, {2'h3, 8'h1D, 8'h1F},
			{2'h3, 8'h1E, 8'h10}, {2'h3, 8'h1F, 8'h00}, {2'h2, 8'h15, 8'h17},
			{2'h2, 8'h17, 8'h11}, {2'h2, 8'h18, 8'h00}, {2'h1, 8'h11, 8'h13},
			{2'h1, 8'h13, 8'h11}, {2'h1, 8'h14, 8'h00}, {2'h3, 8'h05, 8'h00},
			{2'h0, 8'h05, 8'h00}, {2'h3, 8'h05, 8'h00}};
		int nb;
		foreach (tab[i]) begin
			@(negedge mclk) ratio = tab[i][17:16];
			nb = n_burst;
			wr(`SCD_ADDR_DELAY_CTRL, tab[i][15:8]);
			check({3'h0, dly_en, dly_code}, tab[i][15:8] & 8'h1F, "ctrl fields");
			check({3'h0, delay_a}, tab[i][7:0], "delay a");
			check({3'h0, delay_b}, tab[i][7:0], "delay b");
			check(8'(n_burst - nb), 8'h01, "restart count");
		end
	endtask
	// Unmapped place and an aborted frame leave trim A alone
	task automatic t_refuse;
		wr(15'h0016, 8'hAA);
		rd(15'h0016);
		check(q, 8'h00, "unmapped read");
		host.xfer({1'b0, `SCD_ADDR_TRIM_A, 8'h11}, 20, q);
		rd(`SCD_ADDR_TRIM_A);
		check(q, 8'h4F, "aborted write");
	endtask
	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		ratio = 2'h3;
		n_fail = 0;
		comparisons = 0;
		n_burst = 0;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		t_reset();
		t_trim();
		t_delay();
		t_refuse();
		summarize();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		summarize();
	end
endmodule

// ===== hdl/scd_clock_delay_trim.sv
/*
 * Input imbalance trim registers for both channels and the coarse
 * sampling clock delay control, reached over the serial configuration port.
 * Assumes the divide ratio comes from the divider's own register and that
 * everything runs on the input sampling clock mclk.
 */
`timescale 1ns/1ps
`include "scd_defines.svh"

module scd_clock_delay_trim (
	input wire logic mclk,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_en,
	input wire logic [1:0] sample_clock_divide_ratio,
	output logic [2:0] amplitude_trim_a,
	output logic [3:0] phase_trim_a,
	output logic [2:0] amplitude_trim_b,
	output logic [3:0] phase_trim_b,
	output scd_pkg::scd_trim_type trim_a,
	output scd_pkg::scd_trim_type trim_b,
	output logic coarse_delay_enable,
	output logic [3:0] coarse_delay_code,
	output scd_pkg::scd_delay_type delay_a,
	output scd_pkg::scd_delay_type delay_b,
	output logic burst_restart
);

	// ------------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------------

	// Amplitude code to skew; reserved code 4 gives none
	function automatic scd_pkg::scd_amp_type amp_decode(input logic [2:0] code);
		scd_pkg::scd_amp_type r;
		r = '0;
		if (code >= 3'h1 && code <= 3'h3) begin
			// Lower on positive input, raise on negative
			r.pos_lowered = 1'b1;
			r.steps = code[1:0];
		end else if (code >= 3'h5) begin
			// Raise on positive input, lower on negative; 5, 6, 7 give 1, 2, 3 steps
			r.steps = code[1:0];
		end else begin
			// Code 0 adds none; reserved code 4 is treated the same
			r = '0;
		end
		return r;
	endfunction

	// Phase code to capacitor side and step count
	function automatic scd_pkg::scd_phase_type phase_decode(input logic [3:0] code);
		scd_pkg::scd_phase_type r;
		r = '0;
		if (code[3]) begin
			// Codes 8 to 15 load the negative input
			r.on_negative = 1'b1;
			// Top code saturates at seven steps, 1.68 pF, instead of wrapping to none
			if (code[2:0] == 3'h7) begin
				r.steps = 3'h7;
			end else begin
				r.steps = code[2:0] + 3'h1;
			end
		end else begin
			// Codes 1 to 7 load the positive input; 0 adds nothing
			r.steps = code[2:0];
		end
		return r;
	endfunction

	// Delay code to half periods; reserved codes give zero and not applied
	function automatic scd_pkg::scd_delay_type delay_decode(input logic [1:0] div,
			input logic en, input logic [3:0] code);
		scd_pkg::scd_delay_type r;
		logic [3:0] lim; // Last code that counts up from 1.0 period
		r = '0;
		lim = 4'h0; // Overwritten for every ratio below
		unique case (div)
			`SCD_DIV_8: lim = 4'hD;
			`SCD_DIV_4: lim = 4'h5;
			`SCD_DIV_2: lim = 4'h1;
			`SCD_DIV_1: lim = 4'h0;
		endcase
		if (!en || div == `SCD_DIV_1) begin
			// Disabled, or divide by one where every code is reserved
			r = '0;
		end else if (code <= lim) begin
			// Code zero is already one whole period
			r.applied = 1'b1;
			r.half_periods = code + 4'h2;
		end else if (code == lim + 4'h1) begin
			r.applied = 1'b1;
			r.half_periods = 4'h0;
		end else if (code == lim + 4'h2 && div != `SCD_DIV_8) begin
			r.applied = 1'b1;
			r.half_periods = 4'h1;
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Serial port
	// ------------------------------------------------------------------
	scd_pkg::scd_write_type write_req; // Write strobe with address and data
	logic [14:0] rd_addr; // Address of the current frame
	logic [7:0] rd_data; // Read data for that address

	// Shares mclk; the serial clock is only sampled, never used as a clock
	scd_serial_port port (
		.mclk(mclk),
		.rst(rst),
		.spi_cs_n(spi_cs_n),
		.spi_sclk(spi_sclk),
		.spi_sdi(spi_sdi),
		.rd_data(rd_data),
		.rd_addr(rd_addr),
		.spi_sdo(spi_sdo),
		.spi_sdo_en(spi_sdo_en),
		.write_req(write_req)
	);

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic [7:0] input_imbalance_trim_a; // Channel A trims
	logic [7:0] input_imbalance_trim_b; // Channel B trims
	logic [7:0] coarse_clock_delay_ctrl; // Shared delay control

	// Write decode
	wire hit_a = write_req.wr && write_req.addr == `SCD_ADDR_TRIM_A;
	wire hit_b = write_req.wr && write_req.addr == `SCD_ADDR_TRIM_B;
	wire hit_dly = write_req.wr && write_req.addr == `SCD_ADDR_DELAY_CTRL;

	// Reserved bits are stored as written; host keeps them zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			input_imbalance_trim_a <= `SCD_RST_TRIM_A;
			input_imbalance_trim_b <= `SCD_RST_TRIM_B;
			coarse_clock_delay_ctrl <= `SCD_RST_DELAY_CTRL;
		end else begin
			if (hit_a) begin
				input_imbalance_trim_a <= write_req.data;
			end
			if (hit_b) begin
				input_imbalance_trim_b <= write_req.data;
			end
			if (hit_dly) begin
				// Host must not do this during calibration
				coarse_clock_delay_ctrl <= write_req.data;
			end
		end
	end

	// Restart the burst engine on every delay control write, same value or not
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			burst_restart <= 1'b0;
		end else begin
			burst_restart <= hit_dly;
		end
	end

	// Read mux; unmapped addresses read zero
	// Reserved bits read back as stored, so a host can check its own writes
	assign rd_data = (rd_addr == `SCD_ADDR_TRIM_A) ? input_imbalance_trim_a :
		(rd_addr == `SCD_ADDR_TRIM_B) ? input_imbalance_trim_b :
		(rd_addr == `SCD_ADDR_DELAY_CTRL) ? coarse_clock_delay_ctrl : 8'h00;

	// ------------------------------------------------------------------
	// Field outputs
	// ------------------------------------------------------------------
	assign amplitude_trim_a = input_imbalance_trim_a[`SCD_AMP_HI:`SCD_AMP_LO];
	assign phase_trim_a = input_imbalance_trim_a[`SCD_PHASE_HI:`SCD_PHASE_LO];
	assign amplitude_trim_b = input_imbalance_trim_b[`SCD_AMP_HI:`SCD_AMP_LO];
	assign phase_trim_b = input_imbalance_trim_b[`SCD_PHASE_HI:`SCD_PHASE_LO];
	assign coarse_delay_enable = coarse_clock_delay_ctrl[`SCD_DLY_EN_BIT];
	assign coarse_delay_code = coarse_clock_delay_ctrl[`SCD_DLY_CODE_HI:`SCD_DLY_CODE_LO];

	// ------------------------------------------------------------------
	// Decoded controls for the analog networks and clock phase
	// ------------------------------------------------------------------
	scd_pkg::scd_delay_type next_delay; // Delay for the active ratio

	// Ratio changes re-evaluate the code at once
	assign next_delay = delay_decode(sample_clock_divide_ratio,
		coarse_delay_enable, coarse_delay_code);

	// Decoded values registered so the analog side sees clean levels
	// Trade-off: one cycle of latency buys glitch-free control levels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trim_a <= '0;
			trim_b <= '0;
			delay_a <= '0;
			delay_b <= '0;
		end else begin
			trim_a.amp <= amp_decode(amplitude_trim_a);
			trim_a.phase <= phase_decode(phase_trim_a);
			trim_b.amp <= amp_decode(amplitude_trim_b);
			trim_b.phase <= phase_decode(phase_trim_b);
			// Same delay on both channels' clocks
			delay_a <= next_delay;
			delay_b <= next_delay;
		end
	end

endmodule

// ===== hdl/scd_defines.svh
/*
 * Constants for the sample clock delay and input trim register block:
 * register addresses, field positions, reset values and serial frame sizes.
 * Assumes it is included by bare name from design files that need it.
 */
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses on the serial configuration port
// ----------------------------------------------------------------------
`define SCD_ADDR_W 15
`define SCD_ADDR_TRIM_A 15'h0014
`define SCD_ADDR_TRIM_B 15'h0015
`define SCD_ADDR_DELAY_CTRL 15'h0019

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SCD_RST_TRIM_A 8'h00
`define SCD_RST_TRIM_B 8'h00
`define SCD_RST_DELAY_CTRL 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCD_AMP_HI 6
`define SCD_AMP_LO 4
`define SCD_PHASE_HI 3
`define SCD_PHASE_LO 0
`define SCD_DLY_EN_BIT 4
`define SCD_DLY_CODE_HI 3
`define SCD_DLY_CODE_LO 0

// ----------------------------------------------------------------------
// Divide ratio encodings
// ----------------------------------------------------------------------
`define SCD_DIV_1 2'h0
`define SCD_DIV_2 2'h1
`define SCD_DIV_4 2'h2
`define SCD_DIV_8 2'h3

// ----------------------------------------------------------------------
// Serial frame: read flag, 15 address bits, 8 data bits
// ----------------------------------------------------------------------
`define SCD_FRAME_BITS 5'h18
`define SCD_HDR_LAST 5'h0F
`define SCD_DATA_FIRST 5'h10
`define SCD_SHIFT_FIRST 5'h11
`define SCD_DATA_LAST 5'h17

`endif

// ===== hdl/scd_pkg.sv
/*
 * Types shared by the sample clock delay and trim register block.
 * Assumes nothing of its surroundings.
 */
package scd_pkg;

	// One register write taken from the serial port
	typedef struct packed {
		logic wr;
		logic [14:0] addr;
		logic [7:0] data;
	} scd_write_type;

	// Decoded amplitude trim: steps of 10 ohm
	typedef struct packed {
		logic pos_lowered;
		logic [1:0] steps;
	} scd_amp_type;

	// Decoded phase trim: steps of 0.24 pF
	typedef struct packed {
		logic on_negative;
		logic [2:0] steps;
	} scd_phase_type;

	// Both trims of one channel
	typedef struct packed {
		scd_amp_type amp;
		scd_phase_type phase;
	} scd_trim_type;

	// Coarse delay applied to both sampling clocks
	typedef struct packed {
		logic applied;
		logic [3:0] half_periods;
	} scd_delay_type;

endpackage

// ===== hdl/scd_serial_port.sv
/*
 * Serial configuration port slave: 24-bit frames, read flag first,
 * then address and data, most significant bit first.
 * Assumes chip select, serial clock and data are synchronous to mclk and
 * the serial clock is much slower than mclk.
 */
`timescale 1ns/1ps
`include "scd_defines.svh"

module scd_serial_port (
	input wire logic mclk,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	input wire logic [7:0] rd_data,
	output logic [14:0] rd_addr,
	output logic spi_sdo,
	output logic spi_sdo_en,
	output scd_pkg::scd_write_type write_req
);

	// ------------------------------------------------------------------
	// Edge detection on the serial clock
	// ------------------------------------------------------------------
	logic sclk_q; // Previous serial clock level
	logic [4:0] bit_cnt; // Bits taken in this frame
	logic [22:0] shift_in; // Incoming bits
	logic rd_flag; // Frame is a read
	logic load_rd; // Read data is loaded next cycle
	logic [7:0] shift_out; // Outgoing read data
	wire rise = spi_sclk & ~sclk_q & ~spi_cs_n;
	wire fall = ~spi_sclk & sclk_q & ~spi_cs_n;
	wire in_frame = bit_cnt < `SCD_FRAME_BITS;

	assign spi_sdo = shift_out[7];
	// Drive only during the data phase of a read
	assign spi_sdo_en = ~spi_cs_n & rd_flag & (bit_cnt >= `SCD_DATA_FIRST);

	// Serial clock history
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= spi_sclk;
		end
	end

	// ------------------------------------------------------------------
	// Frame shifter
	// ------------------------------------------------------------------
	// Extra clocks past 24 bits are ignored until chip select rises
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bit_cnt <= 5'h00;
			shift_in <= 23'h000000;
			rd_flag <= 1'b0;
			rd_addr <= 15'h0000;
			load_rd <= 1'b0;
			shift_out <= 8'h00;
			write_req <= '0;
		end else begin
			load_rd <= 1'b0;
			write_req.wr <= 1'b0;
			if (spi_cs_n) begin
				// Frame aborted or ended
				bit_cnt <= 5'h00;
				rd_flag <= 1'b0;
			end else if (rise && in_frame) begin
				shift_in <= {shift_in[21:0], spi_sdi};
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == `SCD_HDR_LAST) begin
					// Header complete: flag and address known
					rd_flag <= shift_in[14];
					rd_addr <= {shift_in[13:0], spi_sdi};
					load_rd <= shift_in[14];
				end
				if (bit_cnt == `SCD_DATA_LAST && !rd_flag) begin
					write_req.wr <= 1'b1;
					write_req.addr <= rd_addr;
					write_req.data <= {shift_in[6:0], spi_sdi};
				end
			end else if (load_rd) begin
				// Address already registered, read data now valid
				shift_out <= rd_data;
			end else if (fall && bit_cnt >= `SCD_SHIFT_FIRST && in_frame) begin
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end

endmodule
